// ==== design/irs_event_select.sv ====
// Ingress and retry event selection with a bank of event counters.
// Assumes queue conditions come from logic on core_clk, registered; control is static
// while counting or changes take effect on the next cycle.
//
// Functional notes
// - With the fill-level event chosen, each cycle adds the valid entries of the selected ingress queues.
// - Only counter zero implements the fill-level event; others count nothing for it.
// - Sub-select bits 15:8 are a queue mask: bit 0 request, bit 1 rejected request, bit 2 probe, bit 6 remote response, bit 7 writeback.
// - Codes 2E/2F count retry-queue inserts of entries already in another retry queue, by next reject reason.
// - Class-0 sub-select bits 0..7 are the six vnet0 message classes, then non-link ack, then non-link inval.
// - Class-1 sub-select bits 0..7 are any, home agent, cache evict, filter evict, victim, way, snoop, address.
// - Codes 20/21 count probe-request-queue rejects by class-0 and class-1 causes.
// - Codes 2A/2B count retries of request, probe-request, probe, remote-response and writeback queues only.
// - Codes 26/27 count remote-response-queue retries by class-0 and class-1 causes.
//
// Counters wrap at full width with no overflow flag; software reads and clears them in time.
// The response-side retry input is wired in for uniformity but no event counts it.
`timescale 1ns/100ps
module irs_event_select
    import irs_pkg::*;
#(
    parameter int unsigned NUM_CTR = IRS_NUM_CTR,
    parameter int unsigned CNT_W   = IRS_CNT_W
)
(
    input  wire logic                           core_clk,
    input  wire logic                           rst_n,
    input  wire logic                           clk_en,
    input  wire irs_pkg::irs_ctl_t [NUM_CTR-1:0] ctr_ctl,
    input  wire logic [NUM_CTR-1:0]             ctr_enable,
    input  wire logic [NUM_CTR-1:0]             ctr_clear,
    input  wire irs_pkg::irs_occ_t              queue_fill,
    input  wire irs_pkg::irs_cause_t            probe_req_reject,
    input  wire irs_pkg::irs_cause_t            remote_resp_retry,
    input  wire irs_pkg::irs_cause_t            request_queue_retry,
    input  wire irs_pkg::irs_cause_t            probe_queue_retry,
    input  wire irs_pkg::irs_cause_t            writeback_queue_retry,
    input  wire irs_pkg::irs_cause_t            probe_req_retry,
    input  wire irs_pkg::irs_cause_t            response_queue_retry,
    input  wire irs_pkg::irs_cause_t            repeat_retry,
    output logic [NUM_CTR-1:0][CNT_W-1:0]       ctr_value,
    output logic [NUM_CTR-1:0]                  ctr_active,
    output logic                                fill_mix_error
);
    import irs_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Decoding helpers

    // Unknown codes count nothing rather than aliasing onto a known event
    function automatic irs_mode_t mode_of(input logic [IRS_CODE_W-1:0] code, input int unsigned idx);
        case (code)
            IRS_EV_FILL_LEVEL: mode_of = (idx == 0) ? IRS_MODE_FILL : IRS_MODE_IDLE;
            IRS_EV_PRQ_REJ_C0, IRS_EV_PRQ_REJ_C1,
            IRS_EV_RRQ_REJ_C0, IRS_EV_RRQ_REJ_C1,
            IRS_EV_REQGRP_C0,  IRS_EV_REQGRP_C1,
            IRS_EV_REPEAT_C0,  IRS_EV_REPEAT_C1: mode_of = IRS_MODE_CAUSE;
            default: mode_of = IRS_MODE_IDLE;
        endcase
    endfunction : mode_of

    // Odd codes pick the class-1 cause vector, even ones class 0
    function automatic logic [IRS_SUB_W-1:0] cls(input irs_cause_t c, input logic odd);
        cls = odd ? c.class1 : c.class0;
    endfunction : cls

    // Single hit per cycle however many causes match
    function automatic logic hit(input logic [IRS_SUB_W-1:0] causes, input logic [IRS_SUB_W-1:0] sel);
        hit = |(causes & sel);
    endfunction : hit

    ////////////////////////////////////////////////////////////////////////////
    // Registered queue inputs
    // One stage here keeps the cause OR trees off the counter adder path

    irs_occ_t   fill_q;
    irs_cause_t prq_rej_q;
    irs_cause_t rrq_q;
    irs_cause_t grp_q;
    irs_cause_t rep_q;

    // Response-side queue retries are deliberately left out of the group
    irs_cause_t grp_d;
    always_comb begin
        grp_d = request_queue_retry
              | probe_req_retry
              | probe_queue_retry
              | remote_resp_retry
              | writeback_queue_retry;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fill_q    <= '0;
            prq_rej_q <= '0;
            rrq_q     <= '0;
            grp_q     <= '0;
            rep_q     <= '0;
        end else if (clk_en) begin
            fill_q    <= queue_fill;
            prq_rej_q <= probe_req_reject;
            rrq_q     <= remote_resp_retry;
            grp_q     <= grp_d;
            rep_q     <= repeat_retry;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Fill-level sum for counter zero
    // Only counter zero gets the adder; the others could never use it

    logic [IRS_OCC_W+2:0] fill_sum;

    irs_fill_sum u_fill_sum (
        .queue_mask (ctr_ctl[0].sub_sel),
        .occ        (fill_q),
        .fill_sum   (fill_sum)
    );

    // Flag an unsupported mix of the rejected-request bit with other bits
    // The mixed mask still counts; the flag only warns that the sum means little
    logic fill_mix_d;
    always_comb begin
        fill_mix_d = (ctr_ctl[0].code == IRS_EV_FILL_LEVEL)
                   && ctr_ctl[0].sub_sel[IRS_OCC_REQREJ_BIT]
                   && ((ctr_ctl[0].sub_sel & ~(8'h01 << IRS_OCC_REQREJ_BIT)) != 8'h00);
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fill_mix_error <= 1'b0;
        end else if (clk_en) begin
            fill_mix_error <= fill_mix_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per-counter decode

    irs_mode_t                         mode_d [NUM_CTR];
    logic [NUM_CTR-1:0][IRS_SUB_W-1:0] cause_d;

    // Decoded once and shared by the adder and the active flags
    always_comb begin
        for (int i = 0; i < NUM_CTR; i++) begin
            mode_d[i] = mode_of(ctr_ctl[i].code, i);
        end
    end

    // Cause vector of the watched queue, class picked by the code's low bit
    always_comb begin
        for (int i = 0; i < NUM_CTR; i++) begin
            logic odd;
            odd        = ctr_ctl[i].code[0];
            cause_d[i] = '0;
            case (ctr_ctl[i].code & 8'hFE)
                IRS_EV_PRQ_REJ_C0: cause_d[i] = cls(prq_rej_q, odd);
                IRS_EV_RRQ_REJ_C0: cause_d[i] = cls(rrq_q, odd);
                IRS_EV_REQGRP_C0:  cause_d[i] = cls(grp_q, odd);
                IRS_EV_REPEAT_C0:  cause_d[i] = cls(rep_q, odd);
                default:           cause_d[i] = '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Counter bank

    logic [NUM_CTR-1:0][CNT_W-1:0] inc_d;

    // Fill level adds a whole count, a cause event at most one
    always_comb begin
        for (int i = 0; i < NUM_CTR; i++) begin
            case (mode_d[i])
                IRS_MODE_FILL:  inc_d[i] = CNT_W'(fill_sum);
                IRS_MODE_CAUSE: inc_d[i] = CNT_W'(hit(cause_d[i], ctr_ctl[i].sub_sel));
                default:        inc_d[i] = '0;
            endcase
        end
    end

    // Clear beats a same-cycle increment so a cleared counter always reads zero
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_CTR; i++) begin
                ctr_value[i] <= CNT_W'(IRS_CNT_RST);
            end
        end else if (clk_en) begin
            for (int i = 0; i < NUM_CTR; i++) begin
                if (ctr_clear[i]) begin
                    ctr_value[i] <= CNT_W'(IRS_CNT_RST);
                end else if (ctr_enable[i]) begin
                    ctr_value[i] <= ctr_value[i] + inc_d[i];
                end
            end
        end
    end

    // Shows which enabled counters hold an event they can really count
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctr_active <= '0;
        end else if (clk_en) begin
            for (int i = 0; i < NUM_CTR; i++) begin
                ctr_active[i] <= ctr_enable[i] && (mode_d[i] != IRS_MODE_IDLE);
            end
        end
    end

endmodule : irs_event_select

// ==== design/irs_pkg.sv ====
// Package for the ingress retry event select block.
// Holds event codes, sub-select layout, queue masks and widths shared by all files.
package irs_pkg;

    localparam int unsigned IRS_CODE_W   = 8;
    localparam int unsigned IRS_SUB_W    = 8;
    localparam int unsigned IRS_CNT_W    = 48;
    localparam int unsigned IRS_OCC_W    = 7;
    localparam int unsigned IRS_NUM_CTR  = 4;

    localparam int unsigned IRS_SUB_LSB  = 8;
    localparam int unsigned IRS_SUB_MSB  = 15;

    localparam logic [7:0] IRS_EV_FILL_LEVEL    = 8'h11;
    localparam logic [7:0] IRS_EV_PRQ_REJ_C0    = 8'h20;
    localparam logic [7:0] IRS_EV_PRQ_REJ_C1    = 8'h21;
    localparam logic [7:0] IRS_EV_RRQ_REJ_C0    = 8'h26;
    localparam logic [7:0] IRS_EV_RRQ_REJ_C1    = 8'h27;
    localparam logic [7:0] IRS_EV_REQGRP_C0     = 8'h2A;
    localparam logic [7:0] IRS_EV_REQGRP_C1     = 8'h2B;
    localparam logic [7:0] IRS_EV_REPEAT_C0     = 8'h2E;
    localparam logic [7:0] IRS_EV_REPEAT_C1     = 8'h2F;

    // Occupancy queue-select bit positions within the sub-select byte
    localparam int unsigned IRS_OCC_REQ_BIT     = 0;
    localparam int unsigned IRS_OCC_REQREJ_BIT  = 1;
    localparam int unsigned IRS_OCC_PROBE_BIT   = 2;
    localparam int unsigned IRS_OCC_RRESP_BIT   = 6;
    localparam int unsigned IRS_OCC_WB_BIT      = 7;

    localparam logic [IRS_CNT_W-1:0] IRS_CNT_RST = 48'h0;
    localparam logic [7:0]           IRS_SEL_RST = 8'h00;

    // Counter control word as programmed by software
    typedef struct packed {
        logic [IRS_CODE_W-1:0] code;
        logic [IRS_SUB_W-1:0]  sub_sel;
    } irs_ctl_t;

    // Per-cycle cause vector of one queue, bit i = sub-select bit i
    typedef struct packed {
        logic [IRS_SUB_W-1:0] class1;
        logic [IRS_SUB_W-1:0] class0;
    } irs_cause_t;

    // Valid entry counts of the ingress queues
    typedef struct packed {
        logic [IRS_OCC_W-1:0] req;
        logic [IRS_OCC_W-1:0] req_rej;
        logic [IRS_OCC_W-1:0] probe;
        logic [IRS_OCC_W-1:0] rresp;
        logic [IRS_OCC_W-1:0] wb;
    } irs_occ_t;

    typedef enum logic [1:0] {
        IRS_MODE_IDLE  = 2'b00,
        IRS_MODE_FILL  = 2'b01,
        IRS_MODE_CAUSE = 2'b10
    } irs_mode_t;

endpackage : irs_pkg

// ==== design/irs_fill_sum.sv ====
// Adds the entry counts of the ingress queues chosen by a queue mask.
// Assumes counts are registered in the same clock domain; result is combinational.
`timescale 1ns/100ps
module irs_fill_sum
    import irs_pkg::*;
(
    input  wire logic [IRS_SUB_W-1:0] queue_mask,
    input  wire irs_occ_t             occ,
    output logic [IRS_OCC_W+2:0]      fill_sum
);

    localparam int unsigned SW = IRS_OCC_W + 3;

    function automatic logic [SW-1:0] pick(input logic en, input logic [IRS_OCC_W-1:0] n);
        pick = en ? {3'h0, n} : {SW{1'b0}};
    endfunction : pick

    always_comb begin
        fill_sum = pick(queue_mask[IRS_OCC_REQ_BIT], occ.req)
                 + pick(queue_mask[IRS_OCC_REQREJ_BIT], occ.req_rej)
                 + pick(queue_mask[IRS_OCC_PROBE_BIT], occ.probe)
                 + pick(queue_mask[IRS_OCC_RRESP_BIT], occ.rresp)
                 + pick(queue_mask[IRS_OCC_WB_BIT], occ.wb);
    end

endmodule : irs_fill_sum

// ==== test/irs_event_select_props.sv ====
// Checker of the event select counters, seeing only the block's ports.
// Single clock domain; attached to every instance by the bind at the foot.
`timescale 1ns/100ps
module irs_event_select_props
    import irs_pkg::*;
#(
    parameter int unsigned NUM_CTR = IRS_NUM_CTR,
    parameter int unsigned CNT_W   = IRS_CNT_W
)
(
    input wire logic                            core_clk,
    input wire logic                            rst_n,
    input wire logic                            clk_en,
    input wire irs_pkg::irs_ctl_t [NUM_CTR-1:0] ctr_ctl,
    input wire logic [NUM_CTR-1:0]              ctr_enable,
    input wire logic [NUM_CTR-1:0]              ctr_clear,
    input wire irs_pkg::irs_occ_t               queue_fill,
    input wire irs_pkg::irs_cause_t             probe_req_reject,
    input wire irs_pkg::irs_cause_t             remote_resp_retry,
    input wire logic [NUM_CTR-1:0][CNT_W-1:0]   ctr_value,
    input wire logic [NUM_CTR-1:0]              ctr_active,
    input wire logic                            fill_mix_error
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////
    wire logic       go0 = clk_en && ctr_enable[0] && !ctr_clear[0];
    wire logic       go1 = clk_en && ctr_enable[1] && !ctr_clear[1];
    wire logic [7:0] cd1 = ctr_ctl[1].code;
    logic [1:0]      up_q;
    // Keeps two-deep lookbacks out of the reset span
    always_ff @(posedge core_clk or negedge rst_n)
        if (!rst_n) up_q <= 2'd0;
        else if (!up_q[1]) up_q <= up_q + 2'd1;
    function automatic logic [CNT_W-1:0] fsum(irs_occ_t f, logic [7:0] m);
        return CNT_W'(m[0] ? f.req : 7'd0) + CNT_W'(m[1] ? f.req_rej : 7'd0) + CNT_W'(m[2] ? f.probe : 7'd0)
            + CNT_W'(m[6] ? f.rresp : 7'd0) + CNT_W'(m[7] ? f.wb : 7'd0);
    endfunction : fsum
    property p_fill_add;
        up_q[1] && $past(go0 && ctr_ctl[0].code == 8'h11) && $past(clk_en, 2)
            |-> ctr_value[0] == $past(ctr_value[0]) + fsum($past(queue_fill, 2), $past(ctr_ctl[0].sub_sel));
    endproperty
    a_fill_add: assert property (p_fill_add) else $error("fill sum not added");
    property p_no_fill;
        $past(cd1 == 8'h11 && !ctr_clear[1]) |-> $stable(ctr_value[1]);
    endproperty
    a_no_fill: assert property (p_no_fill) else $error("fill counted off counter 0");
    property p_prq;
        up_q[1] && $past(go1 && cd1 == 8'h20) && $past(clk_en, 2) |-> ctr_value[1] - $past(ctr_value[1])
            == CNT_W'(|($past(probe_req_reject.class0, 2) & $past(ctr_ctl[1].sub_sel)));
    endproperty
    a_prq: assert property (p_prq) else $error("probe request reject count wrong");
    property p_rrq;
        up_q[1] && $past(go1 && cd1 == 8'h27) && $past(clk_en, 2) |-> ctr_value[1] - $past(ctr_value[1])
            == CNT_W'(|($past(remote_resp_retry.class1, 2) & $past(ctr_ctl[1].sub_sel)));
    endproperty
    a_rrq: assert property (p_rrq) else $error("remote response retry count wrong");
    property p_clear;
        $past(clk_en && ctr_clear[1]) |-> ctr_value[1] == '0;
    endproperty
    a_clear: assert property (p_clear) else $error("clear ignored");
    property p_freeze;
        !$past(clk_en) |-> $stable(ctr_value) && $stable(ctr_active) && $stable(fill_mix_error);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while frozen");
    property p_active;
        up_q[1] && $past(clk_en) |-> ctr_active[1]
            == $past(ctr_enable[1] && cd1 inside {8'h20, 8'h21, 8'h26, 8'h27, 8'h2A, 8'h2B, 8'h2E, 8'h2F});
    endproperty
    a_active: assert property (p_active) else $error("active flag wrong");
    property p_mix;
        up_q[1] && $past(clk_en) |-> fill_mix_error
            == $past(ctr_ctl[0].code == 8'h11 && ctr_ctl[0].sub_sel[1] && |(ctr_ctl[0].sub_sel & 8'hFD));
    endproperty
    a_mix: assert property (p_mix) else $error("mix flag wrong");
endmodule : irs_event_select_props
bind irs_event_select irs_event_select_props #(.NUM_CTR(NUM_CTR), .CNT_W(CNT_W)) i_props (.*);

// ==== test/irs_event_select_tb.sv ====
// Bench of the event select block: cause table on counter 1, then fill sum, freeze, mix flag, reset.
// Drives every port itself; no partner model.
`timescale 1ns/100ps
module irs_event_select_tb;
    import irs_pkg::*;
    typedef struct {logic [7:0] c; logic [7:0] s; int q; logic [15:0] v; logic [47:0] e;} irs_row_t;
    logic             core_clk = 1'b0;
    logic             rst_n = 1'b0;
    logic             clk_en = 1'b1;
    irs_ctl_t [3:0]   ctr_ctl = '0;
    logic [3:0]       ctr_enable = '0;
    logic [3:0]       ctr_clear = '0;
    irs_occ_t         queue_fill = '0;
    irs_cause_t       src [8] = '{default: '0};
    logic [3:0][47:0] ctr_value;
    logic [3:0]       ctr_active;
    logic             fill_mix_error;
    int               n_errors = 0;
    int               total_checks = 0;
    // Source: 0 prq reject, 1 remote resp, 2 request, 3 probe, 4 writeback, 5 prq retry, 6 response, 7 repeat
    irs_row_t rows [18] = '{
        '{8'h20, 8'h01, 0, 16'h0001, 1}, '{8'h20, 8'h40, 0, 16'h0080, 0}, '{8'h21, 8'h80, 0, 16'h8000, 1},
        '{8'h21, 8'h80, 0, 16'h0080, 0}, '{8'h26, 8'h40, 1, 16'h0040, 1}, '{8'h27, 8'h10, 1, 16'h1000, 1},
        '{8'h2A, 8'hFF, 2, 16'h0001, 1}, '{8'h2A, 8'hFF, 3, 16'h0004, 1}, '{8'h2A, 8'hFF, 4, 16'h0020, 1},
        '{8'h2A, 8'hFF, 5, 16'h0008, 1}, '{8'h2A, 8'hFF, 1, 16'h0002, 1}, '{8'h2A, 8'hFF, 6, 16'h00FF, 0},
        '{8'h2A, 8'hFF, 0, 16'h00FF, 0}, '{8'h2B, 8'h02, 4, 16'h0200, 1}, '{8'h2E, 8'hFF, 7, 16'h00FF, 1},
        '{8'h2F, 8'h04, 7, 16'h0800, 0}, '{8'h2F, 8'h04, 7, 16'h0400, 1}, '{8'h30, 8'hFF, 0, 16'hFFFF, 0}};
    irs_event_select i_dut (.*, .probe_req_reject(src[0]), .remote_resp_retry(src[1]),
        .request_queue_retry(src[2]), .probe_queue_retry(src[3]), .writeback_queue_retry(src[4]),
        .probe_req_retry(src[5]), .response_queue_retry(src[6]), .repeat_retry(src[7]));
    ////////////////////////////////////////////////////////////
    task chk(input logic [47:0] got, input logic [47:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t ns: got %0h, expected %0h", $time, got, exp);
        end
    endtask : chk
    task final_report;
        if (n_errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : final_report
    initial forever #20 core_clk = ~core_clk;
    // Whole run is near 110 cycles; 600 cycles, over five times that, is a hang
    initial begin
        #24000;
        n_errors++;
        final_report();
    end
    initial begin
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            @(posedge core_clk);
            ctr_enable <= 4'hF;
            ctr_ctl[1] <= {rows[i].c, rows[i].s};
            ctr_clear[1] <= 1'b1;
            @(posedge core_clk);
            ctr_clear[1] <= 1'b0;
            src[rows[i].q] <= rows[i].v;
            @(posedge core_clk);
            src[rows[i].q] <= '0;
            repeat (2) @(posedge core_clk);
            #1 chk(ctr_value[1], rows[i].e);
        end
        @(posedge core_clk);
        ctr_ctl[0] <= {IRS_EV_FILL_LEVEL, 8'hFD};
        ctr_ctl[1] <= {IRS_EV_FILL_LEVEL, 8'hFD};
        queue_fill <= {7'd3, 7'd9, 7'd2, 7'd5, 7'd7};
        ctr_clear <= 4'h3;
        @(posedge core_clk);
        ctr_clear <= '0;
        repeat (4) @(posedge core_clk);
        #1 chk(ctr_value[0], 48'd68);
        chk(ctr_value[1], '0);
        chk(48'(fill_mix_error), '0);
        chk(48'(ctr_active), 48'h1);
        @(posedge core_clk);
        clk_en <= 1'b0;
        repeat (3) @(posedge core_clk);
        #1 chk(ctr_value[0], 48'd85);
        @(posedge core_clk);
        clk_en <= 1'b1;
        ctr_ctl[0] <= {IRS_EV_FILL_LEVEL, 8'h03};
        @(posedge core_clk);
        #1 chk(48'(fill_mix_error), 48'd1);
        @(posedge core_clk);
        rst_n <= 1'b0;
        @(posedge core_clk);
        #1 chk(ctr_value[0], '0);
        chk(48'(ctr_active), '0);
        chk(48'(|ctr_value), '0);
        @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        final_report();
    end
endmodule : irs_event_select_tb
